// >>> verilog/sfw_manager.sv
`timescale 1ns/1ps
`include "sfw_defs.svh"

module sfw_manager #(
  parameter int STORE_WIN_CYC = `SFW_STORE_WIN_US * `SFW_CLK_MHZ,
  parameter int FREQ_CNT_MIN = 16,
  parameter int FREQ_CNT_MAX = 262144
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [`SFW_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic servo_enabled,
  input wire logic [4:0] digital_input_func,
  input wire logic digital_input,
  input wire logic [15:0] controlword,
  input wire logic param_needs_power_cycle,
  input wire logic homing_mode_active,
  input wire logic enc_zero_search_fail,
  input wire logic enc_div_count_error,
  input wire logic battery_low,
  input wire logic ctrl_supply_low,
  input wire logic bus_voltage_low,
  input wire logic enc_feedback_abnormal,
  output logic nv_commit,
  output logic [31:0] nv_commit_data,
  output logic [`SFW_ADDR_W-1:0] nv_commit_addr,
  output logic not_ready_indication,
  output logic fault_active,
  output logic [15:0] active_code,
  output logic irq
);

  localparam int NC = `SFW_N_COND;

  function automatic logic bad_home(input logic [7:0] m);
    bad_home = (m == `SFW_HOME_BAD0) || (m == `SFW_HOME_BAD1) ||
      (m == `SFW_HOME_BAD2) || (m == `SFW_HOME_BAD3);
  endfunction : bad_home

  function automatic logic [15:0] cond_code(input int b);
    case (b)
      `SFW_B_PWR_CYCLE: cond_code = `SFW_CODE_PWR_CYCLE;
      `SFW_B_STORE: cond_code = `SFW_CODE_STORE;
      `SFW_B_FREQ_DIV: cond_code = `SFW_CODE_FREQ_DIV;
      `SFW_B_ENC_ALG: cond_code = `SFW_CODE_ENC_ALG;
      `SFW_B_BATTERY: cond_code = `SFW_CODE_BATTERY;
      `SFW_B_HOMING: cond_code = `SFW_CODE_HOMING;
      default: cond_code = `SFW_CODE_NONE;
    endcase
  endfunction : cond_code

  // Asynchronous inputs pass three flops; a change counts when stages two and three agree.
  localparam int NS = 9;
  logic [NS-1:0] async_in;
  logic [NS-1:0] s1_q, s2_q, s3_q, sync_q;
  assign async_in = {digital_input, param_needs_power_cycle, enc_zero_search_fail,
    enc_div_count_error, battery_low, ctrl_supply_low, bus_voltage_low,
    enc_feedback_abnormal, servo_enabled};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A level only moves once two stages agree, so a single metastable sample is ignored.
  // The price is about four cycles of latency on every pin condition except homing, whose input is not synchronised.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= (s2_q & s3_q) | (sync_q & (s2_q | s3_q));
    end
  end

  wire di_s = sync_q[8];
  wire pwr_cyc_s = sync_q[7];
  wire zs_fail_s = sync_q[6];
  wire div_err_s = sync_q[5];
  wire batt_s = sync_q[4];
  wire ctrl_low_s = sync_q[3];
  wire bus_low_s = sync_q[2];
  wire enc_ab_s = sync_q[1];
  wire enabled_s = sync_q[0];

  // Software registers.
  logic [NC-1:0] enable_q;
  logic nv_en_q;
  logic [3:0] freq_sel_q;
  logic [31:0] freq_cnt_q;
  logic [7:0] homing_q;
  logic cw_q;
  logic di_q;
  logic pwr_pending_q;

  wire wr_clear = reg_wr && (reg_addr == `SFW_REG_CLEAR);
  wire wr_enable = reg_wr && (reg_addr == `SFW_REG_ENABLE);
  wire wr_fault_reset = reg_wr && (reg_addr == `SFW_REG_FAULT_RESET);
  wire wr_nv = reg_wr && (reg_addr == `SFW_REG_NV_ENABLE);
  wire wr_fsel = reg_wr && (reg_addr == `SFW_REG_FREQ_SEL);
  wire wr_fcnt = reg_wr && (reg_addr == `SFW_REG_FREQ_CNT);
  wire wr_home = reg_wr && (reg_addr == `SFW_REG_HOMING);
  wire wr_param = reg_wr && (reg_addr == `SFW_REG_PARAM_WR);

  // Reset request sources.
  wire req_param = wr_fault_reset && (reg_wdata == `SFW_FAULT_RESET_CMD);
  // The input function is a static setting; changing it while the pin is high gives no request, as the edge detector follows the pin alone.
  wire di_is_reset = digital_input_func == `SFW_DI_FUNC_RESET;
  wire req_di = di_is_reset && di_s && !di_q;
  wire req_cw = controlword[`SFW_CW_RESET_BIT] && !cw_q;
  wire reset_req = req_param || req_di || req_cw;
  wire fault_reset_ok = reset_req && !enabled_s;

  // Remembers which source gave the latest reset request, for field diagnosis.
  sfw_pkg::sfw_reset_src_t last_src_q;
  sfw_pkg::sfw_reset_src_t last_src_d;
  assign last_src_d = req_cw ? sfw_pkg::SFW_SRC_CW :
    (req_di ? sfw_pkg::SFW_SRC_DI : sfw_pkg::SFW_SRC_PARAM);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_src_q <= sfw_pkg::SFW_SRC_PARAM;
    end else if (reset_req) begin
      last_src_q <= last_src_d;
    end
  end

  // Storage write-rate limiter; a commit happens only while storage is enabled.
  logic [31:0] win_cnt_q;
  logic [15:0] wr_cnt_q;
  logic store_over_q;
  wire win_end = win_cnt_q >= 32'(STORE_WIN_CYC - 1);
  wire commit = wr_param && nv_en_q;
  wire wr_limit = wr_cnt_q >= `SFW_STORE_MAX_WR;
  logic burst_drop_q;
  wire commit_ok = commit && !wr_limit;
  wire commit_drop = commit && wr_limit;

  // Live conditions.
  wire freq_bad = (freq_sel_q == `SFW_FREQ_SEL_DIV) &&
    ((freq_cnt_q < 32'(FREQ_CNT_MIN)) || (freq_cnt_q > 32'(FREQ_CNT_MAX)));
  wire home_bad = homing_mode_active && bad_home(homing_q);
  logic [NC-1:0] cond;
  assign cond[`SFW_B_PWR_CYCLE] = pwr_pending_q;
  assign cond[`SFW_B_STORE] = store_over_q;
  assign cond[`SFW_B_FREQ_DIV] = freq_bad;
  assign cond[`SFW_B_ENC_ALG] = zs_fail_s || div_err_s;
  assign cond[`SFW_B_BATTERY] = batt_s;
  assign cond[`SFW_B_HOMING] = home_bad;
  assign cond[`SFW_B_NOT_READY] = ctrl_low_s || bus_low_s || enc_ab_s;

  // Faults latch; warnings track their cause and drop on a reset request.
  localparam logic [NC-1:0] FAULT_MASK = NC'(1) << `SFW_B_ENC_ALG;
  logic [NC-1:0] active_q, status_q;
  logic [NC-1:0] active_d;
  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_cond
      if (FAULT_MASK[gi]) begin : g_fault
        assign active_d[gi] = cond[gi] ||
          (active_q[gi] && !fault_reset_ok);
      end else begin : g_warn
        // A warning still present after a reset re-raises on the next cycle.
        assign active_d[gi] = cond[gi] && !(active_q[gi] && reset_req);
      end
    end
  endgenerate

  wire [NC-1:0] rise = active_d & ~active_q;
  wire [NC-1:0] status_d = rise | (status_q & ~(wr_clear ? reg_wdata[NC-1:0] : '0));

  // Highest bit wins the displayed code; the fault code then overrides it, so the fault outranks warnings.
  logic [15:0] code_d;
  always_comb begin
    code_d = `SFW_CODE_NONE;
    for (int i = 0; i < NC; i++) begin
      if (active_q[i] && cond_code(i) != `SFW_CODE_NONE) begin
        code_d = cond_code(i);
      end
    end
    if ((active_q & FAULT_MASK) != '0) begin
      code_d = `SFW_CODE_ENC_ALG;
    end
  end

  // Storage starts enabled and the division output starts deselected after power-up.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_q <= '0;
      nv_en_q <= `SFW_NV_EN_RESET;
      freq_sel_q <= `SFW_FREQ_SEL_RESET;
      freq_cnt_q <= 32'h00000000;
      homing_q <= 8'h00;
    end else begin
      if (wr_enable) enable_q <= reg_wdata[NC-1:0];
      if (wr_nv) nv_en_q <= reg_wdata[0];
      if (wr_fsel) freq_sel_q <= reg_wdata[3:0];
      if (wr_fcnt) freq_cnt_q <= reg_wdata;
      if (wr_home) homing_q <= reg_wdata[7:0];
    end
  end

  // Both edge detectors reset to the idle low level, so no false request follows reset.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cw_q <= 1'b0;
      di_q <= 1'b0;
    end else begin
      cw_q <= controlword[`SFW_CW_RESET_BIT];
      di_q <= di_s;
    end
  end

  // The old value keeps running; only a power-up clears the pending flag.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwr_pending_q <= 1'b0;
    end else if (pwr_cyc_s) begin
      pwr_pending_q <= 1'b1;
    end
  end

  // The rate is judged once per window, not per write, to keep the counter small.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      win_cnt_q <= 32'h00000000;
    end else begin
      win_cnt_q <= win_end ? 32'h00000000 : win_cnt_q + 32'h00000001;
    end
  end

  // A write that finds the window full is dropped and remembered, so exactly the
  // allowed number of commits never raises the storage warning by itself.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_cnt_q <= 16'h0000;
      burst_drop_q <= 1'b0;
      store_over_q <= 1'b0;
    end else if (win_end) begin
      wr_cnt_q <= 16'h0000;
      burst_drop_q <= 1'b0;
      store_over_q <= burst_drop_q || commit_drop;
    end else begin
      if (commit_ok) wr_cnt_q <= wr_cnt_q + 16'h0001;
      if (commit_drop) burst_drop_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_q <= '0;
      status_q <= '0;
    end else begin
      active_q <= active_d;
      status_q <= status_d;
    end
  end

  // Read mux.
  logic [31:0] rdata_d;
  always_comb begin
    case (reg_addr)
      `SFW_REG_STATUS: rdata_d = 32'(status_q);
      `SFW_REG_ENABLE: rdata_d = 32'(enable_q);
      `SFW_REG_CODE: rdata_d = {16'h0000, active_code};
      `SFW_REG_NV_ENABLE: rdata_d = {31'h00000000, nv_en_q};
      `SFW_REG_FREQ_SEL: rdata_d = {28'h0000000, freq_sel_q};
      `SFW_REG_FREQ_CNT: rdata_d = freq_cnt_q;
      `SFW_REG_HOMING: rdata_d = {24'h000000, homing_q};
      `SFW_REG_ACTIVE: rdata_d = 32'(active_q);
      `SFW_REG_LAST_SRC: rdata_d = 32'(last_src_q);
      default: rdata_d = 32'h00000000;
    endcase
  end

  // Read data stand for one cycle and are zero otherwise, so no stale word is seen.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 32'h00000000;
    end
  end

  // Data and address move only with a granted commit, so storage never sees a dropped write.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nv_commit <= 1'b0;
      nv_commit_data <= 32'h00000000;
      nv_commit_addr <= '0;
    end else begin
      nv_commit <= commit_ok;
      if (commit_ok) nv_commit_data <= reg_wdata;
      if (commit_ok) nv_commit_addr <= reg_addr;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      not_ready_indication <= 1'b0;
      fault_active <= 1'b0;
      active_code <= `SFW_CODE_NONE;
      irq <= 1'b0;
    end else begin
      not_ready_indication <= active_q[`SFW_B_NOT_READY];
      fault_active <= (active_q & FAULT_MASK) != '0;
      active_code <= code_d;
      irq <= (status_d & enable_q) != '0;
    end
  end

endmodule : sfw_manager

// >>> verilog/sfw_defs.svh
`ifndef SFW_DEFS_SVH
`define SFW_DEFS_SVH

// Register indices on the plain register port.
`define SFW_ADDR_W 4
`define SFW_REG_STATUS 4'h0
`define SFW_REG_CLEAR 4'h1
`define SFW_REG_ENABLE 4'h2
`define SFW_REG_CODE 4'h3
`define SFW_REG_FAULT_RESET 4'h4
`define SFW_REG_NV_ENABLE 4'h5
`define SFW_REG_FREQ_SEL 4'h6
`define SFW_REG_FREQ_CNT 4'h7
`define SFW_REG_HOMING 4'h8
`define SFW_REG_PARAM_WR 4'h9
`define SFW_REG_ACTIVE 4'ha
`define SFW_REG_LAST_SRC 4'hb

// Condition bit positions in the status, active and mask registers.
`define SFW_N_COND 7
`define SFW_B_PWR_CYCLE 0
`define SFW_B_STORE 1
`define SFW_B_FREQ_DIV 2
`define SFW_B_ENC_ALG 3
`define SFW_B_BATTERY 4
`define SFW_B_HOMING 5
`define SFW_B_NOT_READY 6

// Codes shown to software and the host, packed as 0xGNNS (A.GNN.S).
`define SFW_CODE_NONE 16'h0000
`define SFW_CODE_PWR_CYCLE 16'h4260
`define SFW_CODE_STORE 16'h4270
`define SFW_CODE_FREQ_DIV 16'h4280
`define SFW_CODE_ENC_ALG 16'h9200
`define SFW_CODE_BATTERY 16'h9210
`define SFW_CODE_HOMING 16'hd350

`define SFW_FREQ_SEL_DIV 4'h0
`define SFW_FREQ_SEL_RESET 4'h1
`define SFW_NV_EN_RESET 1'b1
`define SFW_FAULT_RESET_CMD 32'h00000001
`define SFW_CW_RESET_BIT 7
`define SFW_DI_FUNC_RESET 5'h05

// Unsupported homing methods.
`define SFW_HOME_BAD0 8'h0f
`define SFW_HOME_BAD1 8'h10
`define SFW_HOME_BAD2 8'h1f
`define SFW_HOME_BAD3 8'h20

// Storage burst limiter: writes allowed per window.
`define SFW_STORE_WIN_US 1000
`define SFW_STORE_MAX_WR 16'h0010
`define SFW_CLK_MHZ 40

`endif

// >>> verilog/sfw_pkg.sv
package sfw_pkg;
  typedef enum logic [1:0] {
    SFW_SRC_PARAM,
    SFW_SRC_DI,
    SFW_SRC_CW
  } sfw_reset_src_t;
endpackage : sfw_pkg

// >>> bench/sfw_manager_properties.sv
`timescale 1ns/1ps
`include "sfw_defs.svh"
module sfw_manager_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic [`SFW_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic servo_enabled,
  input wire logic enc_zero_search_fail,
  input wire logic enc_div_count_error,
  input wire logic battery_low,
  input wire logic ctrl_supply_low,
  input wire logic bus_voltage_low,
  input wire logic enc_feedback_abnormal,
  input wire logic nv_commit,
  input wire logic not_ready_indication,
  input wire logic fault_active,
  input wire logic [15:0] active_code
);
  // Eight-cycle windows cover the input synchroniser plus the output register.
  wire cause = enc_zero_search_fail | enc_div_count_error;
  wire supply_ok = !ctrl_supply_low && !bus_voltage_low && !enc_feedback_abnormal;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_nr_raise: assert property ($rose(ctrl_supply_low) |-> ##[1:8] not_ready_indication)
    else $error("not ready missed");
  a_nr_drop: assert property (supply_ok [*8] |-> !not_ready_indication)
    else $error("not ready stuck");
  a_fault_set: assert property (cause [*8] |-> fault_active)
    else $error("encoder fault missed");
  a_fault_enabled: assert property ((fault_active && servo_enabled) [*8] |=> fault_active)
    else $error("fault cleared while enabled");
  a_fault_cause: assert property ((fault_active && cause) [*8] |=> fault_active)
    else $error("fault cleared with cause");
  a_fault_code: assert property (fault_active |-> active_code == `SFW_CODE_ENC_ALG)
    else $error("fault code wrong");
  a_batt_gone: assert property (!battery_low [*8] |-> active_code != `SFW_CODE_BATTERY)
    else $error("battery warning stuck");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  a_commit_src: assert property (nv_commit |-> $past(reg_wr) &&
    $past(reg_addr) == `SFW_REG_PARAM_WR)
    else $error("commit without write");
  c_fault_cleared: cover property (fault_active ##[1:300] !fault_active);
  c_commit: cover property (nv_commit);
  c_not_ready: cover property ($rose(not_ready_indication));
endmodule : sfw_manager_properties

bind sfw_manager sfw_manager_properties u_props (.clock, .rst, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .servo_enabled, .enc_zero_search_fail, .enc_div_count_error, .battery_low,
  .ctrl_supply_low, .bus_voltage_low, .enc_feedback_abnormal, .nv_commit,
  .not_ready_indication, .fault_active, .active_code);

// >>> bench/sfw_host_model.sv
`timescale 1ns/1ps
`include "sfw_defs.svh"
module sfw_host_model (
  input wire logic clock,
  output logic [15:0] controlword,
  output logic digital_input,
  output logic [4:0] digital_input_func
);
  initial begin
    controlword = 16'h0000;
    digital_input = 1'b0;
    digital_input_func = `SFW_DI_FUNC_RESET;
  end
  // The reset bit acts on its edge only, so it is returned low after each request.
  task automatic cw_reset();
    @(posedge clock) controlword[`SFW_CW_RESET_BIT] <= 1'b1;
    repeat (2) @(posedge clock);
    controlword[`SFW_CW_RESET_BIT] <= 1'b0;
  endtask : cw_reset
  // Held long enough to pass the three-flop input synchroniser.
  task automatic di_reset();
    @(posedge clock) digital_input <= 1'b1;
    repeat (6) @(posedge clock);
    digital_input <= 1'b0;
  endtask : di_reset
endmodule : sfw_host_model

// >>> bench/test_servo_fault_warning_manager.sv
`timescale 1ns/1ps
`include "sfw_defs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module test_servo_fault_warning_manager;
  logic clock, rst, reg_wr, reg_rd, servo_enabled, digital_input, param_needs_power_cycle;
  logic homing_mode_active, enc_zero_search_fail, enc_div_count_error, battery_low;
  logic ctrl_supply_low, bus_voltage_low, enc_feedback_abnormal, nv_commit, irq;
  logic not_ready_indication, fault_active;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] controlword, active_code;
  logic [4:0] digital_input_func;
  int err_total, total_checks, commits, c0;
  logic [31:0] fsel [4] = '{32'h1, 32'h0, 32'h0, 32'h0};
  logic [31:0] fcnt [4] = '{32'hf, 32'hf, 32'h10, 32'h40001};
  logic [31:0] fexp [4] = '{32'h0, 32'h4, 32'h0, 32'h4};
  logic [31:0] bad_home [4] = '{32'hf, 32'h10, 32'h1f, 32'h20};
  sfw_manager #(.STORE_WIN_CYC(20)) dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .servo_enabled, .digital_input_func, .digital_input, .controlword,
    .param_needs_power_cycle, .homing_mode_active, .enc_zero_search_fail, .enc_div_count_error,
    .battery_low, .ctrl_supply_low, .bus_voltage_low, .enc_feedback_abnormal, .nv_commit,
    .nv_commit_data(), .nv_commit_addr(), .not_ready_indication, .fault_active, .active_code, .irq);
  sfw_host_model host (.clock, .controlword, .digital_input, .digital_input_func);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) if (nv_commit === 1'b1) commits <= commits + 1;
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock) begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge clock) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    repeat (3) @(posedge clock);
    @(posedge clock) begin
      reg_rd <= 1'b1;
      reg_addr <= a;
    end
    @(posedge clock) reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic settle();
    repeat (8) @(posedge clock);
  endtask : settle
  task automatic close_out();
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    {reg_wr, reg_rd, servo_enabled, param_needs_power_cycle, homing_mode_active} = '0;
    {enc_zero_search_fail, enc_div_count_error, battery_low} = '0;
    {ctrl_supply_low, bus_voltage_low, enc_feedback_abnormal} = '0;
    {reg_addr, reg_wdata, err_total, total_checks, commits} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(4'hf, 32'h0);
    rd(`SFW_REG_CODE, 32'h0);
    wr(`SFW_REG_ENABLE, 32'h7f);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) {ctrl_supply_low, bus_voltage_low, enc_feedback_abnormal} <= 3'h4 >> i;
      settle();
      `CHK(not_ready_indication, (i < 3))
    end
    `CHK(irq, 1'b1)
    wr(`SFW_REG_CLEAR, 32'h7f);
    wr(`SFW_REG_ENABLE, 32'h0);
    @(posedge clock) battery_low <= 1'b1;
    settle();
    `CHK(irq, 1'b0)
    rd(`SFW_REG_CODE, {16'h0, `SFW_CODE_BATTERY});
    wr(`SFW_REG_ENABLE, 32'h7f);
    settle();
    `CHK(irq, 1'b1)
    @(posedge clock) battery_low <= 1'b0;
    settle();
    rd(`SFW_REG_ACTIVE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`SFW_REG_FREQ_SEL, fsel[i]);
      wr(`SFW_REG_FREQ_CNT, fcnt[i]);
      rd(`SFW_REG_ACTIVE, fexp[i]);
    end
    wr(`SFW_REG_FREQ_CNT, 32'h10);
    @(posedge clock) homing_mode_active <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`SFW_REG_HOMING, bad_home[i]);
      rd(`SFW_REG_CODE, {16'h0, `SFW_CODE_HOMING});
    end
    wr(`SFW_REG_HOMING, 32'h1);
    rd(`SFW_REG_ACTIVE, 32'h0);
    @(posedge clock) begin
      servo_enabled <= 1'b1;
      enc_div_count_error <= 1'b1;
    end
    settle();
    `CHK(fault_active, 1'b1)
    rd(`SFW_REG_CODE, {16'h0, `SFW_CODE_ENC_ALG});
    @(posedge clock) battery_low <= 1'b1;
    settle();
    wr(`SFW_REG_CLEAR, 32'h7f);
    wr(`SFW_REG_FAULT_RESET, `SFW_FAULT_RESET_CMD);
    rd(`SFW_REG_STATUS, 32'h10);
    `CHK(fault_active, 1'b1)
    @(posedge clock) {battery_low, enc_div_count_error} <= 2'b00;
    settle();
    host.cw_reset();
    settle();
    `CHK(fault_active, 1'b1)
    @(posedge clock) {servo_enabled, enc_zero_search_fail} <= 2'b01;
    settle();
    host.di_reset();
    settle();
    `CHK(fault_active, 1'b1)
    for (int s = 0; s < 3; s++) begin
      @(posedge clock) enc_zero_search_fail <= 1'b0;
      settle();
      if (s == 0) wr(`SFW_REG_FAULT_RESET, `SFW_FAULT_RESET_CMD);
      else if (s == 1) host.di_reset();
      else host.cw_reset();
      settle();
      `CHK(fault_active, 1'b0)
      if (s == 2) rd(`SFW_REG_LAST_SRC, 32'h2);
      @(posedge clock) enc_zero_search_fail <= 1'b1;
      settle();
    end
    @(posedge clock) enc_zero_search_fail <= 1'b0;
    settle();
    wr(`SFW_REG_FAULT_RESET, `SFW_FAULT_RESET_CMD);
    wr(`SFW_REG_CLEAR, 32'h7f);
    // Forty back-to-back writes are sure to fill one whole twenty-cycle window.
    @(posedge clock) begin
      reg_wr <= 1'b1;
      reg_addr <= `SFW_REG_PARAM_WR;
    end
    repeat (40) @(posedge clock);
    reg_wr <= 1'b0;
    repeat (25) @(posedge clock);
    rd(`SFW_REG_STATUS, 32'h2);
    repeat (45) @(posedge clock);
    c0 = commits;
    wr(`SFW_REG_PARAM_WR, 32'h5);
    repeat (3) @(posedge clock);
    `CHK(commits, c0 + 1)
    wr(`SFW_REG_NV_ENABLE, 32'h0);
    for (int i = 0; i < 3; i++) wr(`SFW_REG_PARAM_WR, 32'h6);
    repeat (3) @(posedge clock);
    `CHK(commits, c0 + 1)
    @(posedge clock) param_needs_power_cycle <= 1'b1;
    settle();
    rd(`SFW_REG_CODE, {16'h0, `SFW_CODE_PWR_CYCLE});
    close_out();
  end
endmodule : test_servo_fault_warning_manager
